// ---- rtl/hpm_pkg.sv ----
package hpm_pkg;
  // bus mode codes selected at configuration
  typedef enum logic [3:0] {
    HPM_BUS_GENERIC      = 4'h0,
    HPM_BUS_EMBED_WE     = 4'h1,
    HPM_BUS_TWO_STB_UP   = 4'h2,
    HPM_BUS_TWO_STB_SOLE = 4'h3,
    HPM_BUS_ISA          = 4'h4,
    HPM_BUS_CARD_A       = 4'h5,
    HPM_BUS_CARD_B       = 4'h6,
    HPM_BUS_BIG_END      = 4'h7,
    HPM_BUS_PCCARD       = 4'h8
  } hpm_mode_type;

  // one-hot pin function class
  typedef enum logic [4:0] {
    HPM_FN_RESET = 5'h01,
    HPM_FN_PLAIN = 5'h02,
    HPM_FN_CARD  = 5'h04,
    HPM_FN_BIGE  = 5'h08,
    HPM_FN_ISA   = 5'h10
  } hpm_fn_type;

  // upper-byte strobe meaning
  typedef enum logic [2:0] {
    HPM_UB_WE        = 3'h0,
    HPM_UB_BHE       = 3'h1,
    HPM_UB_ODD       = 3'h2,
    HPM_UB_CE2       = 3'h3,
    HPM_UB_UPPER_STB = 3'h4,
    HPM_UB_SOLE_STB  = 3'h5,
    HPM_UB_BI_OUT    = 3'h6,
    HPM_UB_NONE      = 3'h7
  } hpm_ub_type;

  localparam logic [7:0]  HPM_ADDR_RST = 8'h00;
  localparam logic [15:0] HPM_DATA_RST = 16'h0000;
  localparam int          HPM_LO_BYTE  = 0;
  localparam int          HPM_HI_BYTE  = 8;
endpackage

// ---- rtl/hpm_dec_if.sv ----
`timescale 1ns/100ps
interface hpm_dec_if;
  import hpm_pkg::*;
  logic [3:0] mode;
  logic       cfg_done;
  hpm_fn_type fn;
  hpm_ub_type ub;
  modport src (output mode, output cfg_done, input fn, input ub);
  modport dec (input mode, input cfg_done, output fn, output ub);
endinterface

// ---- rtl/hpm_mode_dec.sv ----
`timescale 1ns/100ps
module hpm_mode_dec
  import hpm_pkg::*;
(
  hpm_dec_if.dec d
);
  // ----------------------------------------
  // pin function class and strobe meaning
  // ----------------------------------------
  always_comb begin
    d.fn = HPM_FN_RESET;
    d.ub = HPM_UB_NONE;
    if (d.cfg_done) begin
      case (d.mode)
        HPM_BUS_GENERIC, HPM_BUS_EMBED_WE: begin
          d.fn = HPM_FN_PLAIN;
          d.ub = HPM_UB_WE;
        end
        HPM_BUS_TWO_STB_UP: begin
          d.fn = HPM_FN_PLAIN;
          d.ub = HPM_UB_UPPER_STB;
        end
        HPM_BUS_TWO_STB_SOLE: begin
          d.fn = HPM_FN_PLAIN;
          d.ub = HPM_UB_SOLE_STB;
        end
        HPM_BUS_ISA: begin
          d.fn = HPM_FN_ISA;
          d.ub = HPM_UB_BHE;
        end
        HPM_BUS_CARD_A, HPM_BUS_CARD_B: begin
          d.fn = HPM_FN_CARD;
          d.ub = HPM_UB_ODD;
        end
        HPM_BUS_BIG_END: begin
          d.fn = HPM_FN_BIGE;
          d.ub = HPM_UB_BI_OUT;
        end
        HPM_BUS_PCCARD: begin
          d.fn = HPM_FN_PLAIN;
          d.ub = HPM_UB_CE2;
        end
        default: begin
          d.fn = HPM_FN_PLAIN;
          d.ub = HPM_UB_WE;
        end
      endcase
    end
  end
endmodule

// ---- rtl/hpm_pin_mux.sv ----
`timescale 1ns/100ps
//
// Contract
// - outside card modes, mem/reg select high picks display buffer, low registers
// - outside card modes chip select qualifies access; card hosts tie it high
// - card modes: address pin 20 is the address latch enable
// - card modes: address pin 17 is the card I/O write command
// - card modes: address pin 18 is the card I/O read command
// - card modes: address pin 19 is the card control-register strobe
// - big-endian mode: address pins 18..13 map to bits in reversed numbering; bits 20..19 held low
// - plain modes: address pins 20..13 are system address bits 20..13
// - card modes: device byte 15:8 to host 23:16, byte 7:0 to 31:24
// - generic and embedded modes: upper-byte strobe is high-byte write enable
// - ISA mode: upper-byte strobe is byte-high enable
// - card modes: upper-byte strobe is odd-byte access enable
// - PC Card mode: upper-byte strobe is card enable 2
// - two-strobe modes: upper data strobe, or sole data strobe
// - big-endian mode: upper-byte strobe drives burst inhibit output
//
module hpm_pin_mux
  import hpm_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic [3:0]  i_bus_mode,
  input  wire logic        i_cfg_load,
  input  wire logic [3:0]  i_host_addr_hi,
  input  wire logic        i_host_addr_bit_a,
  input  wire logic        i_host_addr_bit_b,
  input  wire logic        i_host_addr_bit_c,
  input  wire logic        i_host_addr_bit_d,
  input  wire logic        i_mem_reg_sel,
  input  wire logic        i_chip_sel_n,
  input  wire logic [15:0] i_host_data_bus,
  output logic      [15:0] o_host_data_bus,
  output logic      [15:0] o_host_data_bus_oe_n,
  input  wire logic        i_upper_byte_strobe_n,
  output logic             o_upper_byte_strobe_n,
  output logic             o_upper_byte_strobe_oe_n,
  input  wire logic        i_burst_inhibit_n,
  input  wire logic        i_rd_en,
  input  wire logic [15:0] i_rd_data,
  output logic      [20:13] o_sys_addr,
  output logic             o_access_valid,
  output logic             o_access_mem,
  output logic             o_access_reg,
  output logic             o_addr_latch,
  output logic             o_card_io_write_n,
  output logic             o_card_io_read_n,
  output logic             o_card_ctrl_access_n,
  output logic             o_hi_byte_en,
  output logic             o_lo_byte_en,
  output logic      [15:0] o_wr_data,
  output logic      [3:0]  o_mode_q
);

  // ----------------------------------------
  // mode capture
  // ----------------------------------------
  logic       cfg_done_q;
  logic [3:0] mode_q;

  hpm_dec_if dif ();
  assign dif.mode     = mode_q;
  assign dif.cfg_done = cfg_done_q;

  hpm_mode_dec u_dec (
    .d (dif.dec)
  );

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_done_q <= 1'b0;
      mode_q     <= 4'h0;
    end else if (i_cfg_load && !cfg_done_q) begin
      cfg_done_q <= 1'b1;
      mode_q     <= i_bus_mode;
    end
  end

  logic is_card;
  logic is_bige;
  logic live;
  assign is_card = (dif.fn == HPM_FN_CARD);
  assign is_bige = (dif.fn == HPM_FN_BIGE);
  assign live    = (dif.fn != HPM_FN_RESET);

  // ----------------------------------------
  // address mapping
  // ----------------------------------------
  logic [20:13] addr_d;
  logic [4:0]   top_pins;
  assign top_pins = {i_host_addr_bit_d, i_host_addr_bit_c, i_host_addr_bit_b,
                     i_host_addr_bit_a, i_host_addr_hi[3]};

  always_comb begin
    addr_d = HPM_ADDR_RST;
    if (is_bige) begin
      // pins 16..13 carry bits 15..18, pins 17..18 carry bits 14..13, bits 20..19 held low
      addr_d[15] = i_host_addr_hi[3];
      addr_d[16] = i_host_addr_hi[2];
      addr_d[17] = i_host_addr_hi[1];
      addr_d[18] = i_host_addr_hi[0];
      addr_d[14] = i_host_addr_bit_a;
      addr_d[13] = i_host_addr_bit_b;
      addr_d[20:19] = 2'h0;
    end else if (live && !is_card) begin
      // ISA host presents an already latched bit 20
      addr_d = {top_pins, i_host_addr_hi[2:0]};
    end
  end

  logic [20:13] sys_addr_q;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sys_addr_q <= HPM_ADDR_RST;
    end else if (is_card) begin
      if (i_host_addr_bit_d) begin
        sys_addr_q <= {i_host_addr_hi, i_host_data_bus[3:0]};
      end
    end else begin
      sys_addr_q <= addr_d;
    end
  end
  assign o_sys_addr = sys_addr_q;

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_access_valid <= 1'b0;
      o_access_mem   <= 1'b0;
      o_access_reg   <= 1'b0;
    end else if (is_card) begin
      o_access_valid <= !i_host_addr_bit_a || !i_host_addr_bit_b;
      o_access_mem   <= i_host_addr_bit_c;
      o_access_reg   <= !i_host_addr_bit_c;
    end else begin
      o_access_valid <= live && !i_chip_sel_n;
      o_access_mem   <= live && !i_chip_sel_n && i_mem_reg_sel;
      o_access_reg   <= live && !i_chip_sel_n && !i_mem_reg_sel;
    end
  end

  // ----------------------------------------
  // card command pins
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_addr_latch         <= 1'b0;
      o_card_io_write_n    <= 1'b1;
      o_card_io_read_n     <= 1'b1;
      o_card_ctrl_access_n <= 1'b1;
    end else begin
      o_addr_latch         <= is_card && i_host_addr_bit_d;
      o_card_io_write_n    <= !(is_card && !i_host_addr_bit_a);
      o_card_io_read_n     <= !(is_card && !i_host_addr_bit_b);
      o_card_ctrl_access_n <= !(is_card && !i_host_addr_bit_c);
    end
  end

  // ----------------------------------------
  // byte lanes from upper-byte strobe
  // ----------------------------------------
  logic hi_d;
  always_comb begin
    hi_d = 1'b0;
    case (dif.ub)
      HPM_UB_WE:        hi_d = !i_upper_byte_strobe_n;
      HPM_UB_BHE:       hi_d = !i_upper_byte_strobe_n;
      HPM_UB_ODD:       hi_d = !i_upper_byte_strobe_n;
      HPM_UB_CE2:       hi_d = !i_upper_byte_strobe_n;
      HPM_UB_UPPER_STB: hi_d = !i_upper_byte_strobe_n;
      HPM_UB_SOLE_STB:  hi_d = !i_upper_byte_strobe_n;
      HPM_UB_BI_OUT:    hi_d = 1'b1;
      default:          hi_d = 1'b0;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hi_byte_en <= 1'b0;
      o_lo_byte_en <= 1'b0;
    end else begin
      o_hi_byte_en <= live && hi_d;
      o_lo_byte_en <= live && (dif.ub == HPM_UB_SOLE_STB ? hi_d : 1'b1);
    end
  end

  // ----------------------------------------
  // data lanes
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wr_data <= HPM_DATA_RST;
    end else if (is_card) begin
      // device byte 15:8 sits on host 23:16, byte 7:0 on host 31:24
      o_wr_data <= i_host_data_bus;
    end else begin
      // 8-bit hosts hold unused lines high wide hosts use 31:16
      o_wr_data <= i_host_data_bus;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_data_bus      <= HPM_DATA_RST;
      o_host_data_bus_oe_n <= 16'hffff;
    end else begin
      o_host_data_bus      <= i_rd_data;
      o_host_data_bus_oe_n <= {16{!(live && i_rd_en)}};
    end
  end

  // ----------------------------------------
  // burst inhibit output
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_upper_byte_strobe_n    <= 1'b1;
      o_upper_byte_strobe_oe_n <= 1'b1;
    end else begin
      o_upper_byte_strobe_n    <= i_burst_inhibit_n;
      o_upper_byte_strobe_oe_n <= !is_bige;
    end
  end

  assign o_mode_q = mode_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_mode_fixed: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    cfg_done_q |=> (mode_q == $past(mode_q)))
    else $error("bus mode changed after configuration");

  a_reg_space: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (live && !is_card && !i_chip_sel_n && !i_mem_reg_sel) |=> o_access_reg && !o_access_mem)
    else $error("low select did not reach register space");

  a_cs_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!is_card && i_chip_sel_n) |=> !o_access_valid)
    else $error("access without chip select");

  a_ale_pin: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (is_card && i_host_addr_bit_d) |=> o_addr_latch)
    else $error("latch enable not seen");

  a_io_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (is_card && !i_host_addr_bit_a) |=> !o_card_io_write_n)
    else $error("card io write missed");

  a_io_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (is_card && !i_host_addr_bit_b) |=> !o_card_io_read_n)
    else $error("card io read missed");

  a_ctrl_strobe: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (is_card && !i_host_addr_bit_c) |=> !o_card_ctrl_access_n)
    else $error("card control strobe missed");

  a_bige_addr: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    is_bige |=> (o_sys_addr[18] == $past(i_host_addr_hi[0])))
    else $error("reversed address map wrong");

  a_plain_addr: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (live && !is_card && !is_bige) |=> (o_sys_addr[20] == $past(i_host_addr_bit_d)))
    else $error("direct address map wrong");

  a_hi_lane: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (dif.ub == HPM_UB_WE && !i_upper_byte_strobe_n) |=> o_hi_byte_en)
    else $error("high byte write enable missed");

  a_bi_drive: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    is_bige |=> !o_upper_byte_strobe_oe_n)
    else $error("burst inhibit not driven");

  a_mem_space: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (live && !is_card && !i_chip_sel_n && i_mem_reg_sel) |=> o_access_mem && !o_access_reg)
    else $error("high select did not reach display buffer");

  a_bhe_lane: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (dif.ub == HPM_UB_BHE && !i_upper_byte_strobe_n) |=> o_hi_byte_en)
    else $error("byte high enable missed");

  a_odd_lane: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (dif.ub == HPM_UB_ODD && i_upper_byte_strobe_n) |=> !o_hi_byte_en)
    else $error("odd byte lane on without enable");

  a_ce2_lane: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (dif.ub == HPM_UB_CE2 && !i_upper_byte_strobe_n) |=> o_hi_byte_en)
    else $error("card enable 2 missed");

  a_sole_lanes: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (dif.ub == HPM_UB_SOLE_STB && !i_upper_byte_strobe_n) |=> (o_hi_byte_en && o_lo_byte_en))
    else $error("sole strobe did not open both lanes");

  a_card_data: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    is_card |=> (o_wr_data == $past(i_host_data_bus)))
    else $error("card data lanes wrong");

  a_idle_float: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !live |=> ((o_host_data_bus_oe_n == 16'hffff) && o_upper_byte_strobe_oe_n))
    else $error("pins driven before configuration");

endmodule

// ---- test/hpm_host_model.sv ----
`timescale 1ns/100ps
module hpm_host_model (
  input  wire logic [15:0] i_dev_data,
  input  wire logic [15:0] i_dev_oe_n,
  input  wire logic [31:0] i_host_lines,
  input  wire logic        i_host_oe,
  input  wire logic        i_upper_half,
  input  wire logic        i_card_swap,
  output logic      [15:0] o_pin_level
);
  logic [15:0] host_view;

  // ----------------------------------------
  // host data lines seen at the device pins
  // ----------------------------------------
  always_comb begin
    if (i_card_swap) begin
      host_view = {i_host_lines[23:16], i_host_lines[31:24]};
    end else if (i_upper_half) begin
      host_view = i_host_lines[31:16];
    end else begin
      host_view = i_host_lines[15:0];
    end
  end

  // ----------------------------------------
  // pin level: device, else host, else held high
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!i_dev_oe_n[i]) begin
        o_pin_level[i] = i_dev_data[i];
      end else if (i_host_oe) begin
        o_pin_level[i] = host_view[i];
      end else begin
        o_pin_level[i] = 1'b1;
      end
    end
  end
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import hpm_pkg::*;
  // ----------------------------------------
  // stimulus, wiring and counters
  // ----------------------------------------
  logic         clk       = 1'b0;
  logic         rst       = 1'b1;
  logic [3:0]   mode      = 4'h0;
  logic         cfg       = 1'b0;
  logic [3:0]   hi        = 4'h0;
  logic [3:0]   dcba      = 4'hf;
  logic         mr        = 1'b0;
  logic         cs_n      = 1'b1;
  logic         ubs_n     = 1'b1;
  logic         bi_n      = 1'b1;
  logic         rd_en     = 1'b0;
  logic [15:0]  rd_data   = 16'h0000;
  logic [31:0]  lines     = 32'h0000_0000;
  logic         host_oe   = 1'b0;
  logic         upper     = 1'b0;
  logic         swap      = 1'b0;
  logic [15:0]  bus;
  logic [15:0]  dq;
  logic [15:0]  dq_oe_n;
  logic [15:0]  wr_data;
  logic         ub_q;
  logic         ub_oe_n;
  logic         valid;
  logic         mem;
  logic         regs;
  logic         ale;
  logic         iow_n;
  logic         ior_n;
  logic         creg_n;
  logic         hbe;
  logic         lbe;
  logic [20:13] sys_addr;
  logic [3:0]   mode_q;
  int           mismatches = 0;
  int           compares   = 0;
  int           cycles     = 0;
  hpm_mode_type ub_modes [8] = '{HPM_BUS_GENERIC, HPM_BUS_EMBED_WE, HPM_BUS_ISA, HPM_BUS_CARD_A,
    HPM_BUS_CARD_B, HPM_BUS_PCCARD, HPM_BUS_TWO_STB_UP, HPM_BUS_TWO_STB_SOLE};

  hpm_pin_mux DUT (.i_ref_clk(clk), .i_rst(rst), .i_bus_mode(mode), .i_cfg_load(cfg),
    .i_host_addr_hi(hi), .i_host_addr_bit_a(dcba[0]), .i_host_addr_bit_b(dcba[1]),
    .i_host_addr_bit_c(dcba[2]), .i_host_addr_bit_d(dcba[3]), .i_mem_reg_sel(mr),
    .i_chip_sel_n(cs_n), .i_host_data_bus(bus), .o_host_data_bus(dq),
    .o_host_data_bus_oe_n(dq_oe_n), .i_upper_byte_strobe_n(ubs_n),
    .o_upper_byte_strobe_n(ub_q), .o_upper_byte_strobe_oe_n(ub_oe_n),
    .i_burst_inhibit_n(bi_n), .i_rd_en(rd_en), .i_rd_data(rd_data), .o_sys_addr(sys_addr),
    .o_access_valid(valid), .o_access_mem(mem), .o_access_reg(regs), .o_addr_latch(ale),
    .o_card_io_write_n(iow_n), .o_card_io_read_n(ior_n), .o_card_ctrl_access_n(creg_n),
    .o_hi_byte_en(hbe), .o_lo_byte_en(lbe), .o_wr_data(wr_data), .o_mode_q(mode_q));

  hpm_host_model HOST (.i_dev_data(dq), .i_dev_oe_n(dq_oe_n), .i_host_lines(lines),
    .i_host_oe(host_oe), .i_upper_half(upper), .i_card_swap(swap), .o_pin_level(bus));

  always #12.5 clk = ~clk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize();
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic drive(input logic c_n, input logic m, input logic u_n,
                       input logic [3:0] h, input logic [3:0] p);
    @(posedge clk);
    cs_n  <= c_n;
    mr    <= m;
    ubs_n <= u_n;
    hi    <= h;
    dcba  <= p;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic host(input logic oe, input logic up, input logic sw, input logic [31:0] l);
    @(posedge clk);
    host_oe <= oe;
    upper   <= up;
    swap    <= sw;
    lines   <= l;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic restart(input hpm_mode_type m);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("data oe_n in reset", dq_oe_n, 16'hffff);
    chk("strobe oe_n in reset", {15'h0, ub_oe_n}, 16'h0001);
    @(posedge clk);
    rst  <= 1'b0;
    mode <= m;
    @(posedge clk);
    cfg <= 1'b1;
    @(posedge clk);
    cfg <= 1'b0;
    @(negedge clk);
    chk("captured mode", {12'h0, mode_q}, {12'h0, m});
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      summarize();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    restart(HPM_BUS_GENERIC);
    drive(1'b0, 1'b1, 1'b1, 4'ha, 4'b1101);
    chk("valid", {15'h0, valid}, 16'h0001);
    chk("mem reg", {14'h0, mem, regs}, 16'h0002);
    chk("sys addr", {8'h0, sys_addr}, 16'h00da);
    drive(1'b0, 1'b0, 1'b1, 4'h5, 4'b0010);
    chk("mem reg", {14'h0, mem, regs}, 16'h0001);
    chk("sys addr", {8'h0, sys_addr}, 16'h0025);
    drive(1'b1, 1'b1, 1'b1, 4'h0, 4'h0);
    chk("valid idle", {15'h0, valid}, 16'h0000);
    @(posedge clk);
    mode <= HPM_BUS_BIG_END;
    cfg  <= 1'b1;
    rd_en   <= 1'b1;
    rd_data <= 16'h1234;
    @(posedge clk);
    cfg <= 1'b0;
    @(negedge clk);
    chk("mode kept", {12'h0, mode_q}, 16'h0000);
    chk("drive oe_n", dq_oe_n, 16'h0000);
    chk("drive data", dq, 16'h1234);
    @(posedge clk);
    rd_en <= 1'b0;
    host(1'b0, 1'b0, 1'b0, 32'h0000_0000);
    chk("released lines", wr_data, 16'hffff);
    host(1'b1, 1'b0, 1'b0, 32'h0000_0f0f);
    chk("low half data", wr_data, 16'h0f0f);
    for (int i = 0; i < 8; i++) begin
      restart(ub_modes[i]);
      drive(1'b0, 1'b1, 1'b0, 4'h0, 4'b1110); // address bit 20 arrives latched
      chk("hi lane", {15'h0, hbe}, 16'h0001);
      if (ub_modes[i] == HPM_BUS_TWO_STB_SOLE) begin
        chk("lo lane", {15'h0, lbe}, 16'h0001);
      end
      drive(1'b0, 1'b1, 1'b1, 4'h0, 4'b1110);
      chk("hi lane off", {15'h0, hbe}, 16'h0000);
      if (ub_modes[i] == HPM_BUS_TWO_STB_SOLE) begin
        chk("lo lane off", {15'h0, lbe}, 16'h0000);
      end
    end
    host(1'b1, 1'b1, 1'b0, 32'h5a3c_0000);
    chk("upper half data", wr_data, 16'h5a3c);
    restart(HPM_BUS_CARD_B);
    host(1'b1, 1'b0, 1'b1, 32'hbbaa_0000);
    drive(1'b1, 1'b0, 1'b1, 4'h3, 4'b1110);
    chk("card io write", {12'h0, ale, iow_n, ior_n, creg_n}, 16'h000b);
    chk("card valid", {15'h0, valid}, 16'h0001);
    chk("card latched addr", {8'h0, sys_addr}, 16'h003b);
    chk("card data", wr_data, 16'haabb);
    drive(1'b1, 1'b0, 1'b1, 4'h3, 4'b0001);
    chk("card io read", {12'h0, ale, iow_n, ior_n, creg_n}, 16'h0004);
    restart(HPM_BUS_BIG_END);
    @(posedge clk);
    bi_n <= 1'b0;
    drive(1'b0, 1'b1, 1'b1, 4'b0001, 4'b0001);
    chk("reversed addr", {8'h0, sys_addr}, 16'h0022);
    chk("burst inhibit", {14'h0, ub_oe_n, ub_q}, 16'h0000);
    @(posedge clk);
    bi_n <= 1'b1;
    drive(1'b0, 1'b1, 1'b1, 4'b1000, 4'b0010);
    chk("reversed addr", {8'h0, sys_addr}, 16'h0005);
    chk("burst inhibit", {14'h0, ub_oe_n, ub_q}, 16'h0001);
    summarize();
  end
endmodule
